// ### core/bsr_pkg.sv
/*
  Package for the four-stage bidirectional shift register: widths, indices and mode codes.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package bsr_pkg;
  localparam int BSR_STAGES = 4;
  localparam int BSR_FIRST = 0;
  localparam logic BSR_MODE_LOAD = 1'h1;
  localparam logic BSR_MODE_SHIFT = 1'h0;
  localparam int BSR_SYNC_DEPTH = 2;
endpackage

// ### core/bsr_edge_sync.sv
/*
  Two-flop synchroniser with falling-edge pulse for one external clock pin.
  Assumes the pin is asynchronous to clk_in and each level lasts more than three clk_in cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module bsr_edge_sync
  import bsr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  output logic level_out,
  output logic fall_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic prev_q;
  logic prev_d;

  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // The first flop feeds only the second; the edge detector looks at later stages.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
      prev_q <= 1'h0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level_out = sync_q;
  assign fall_out = prev_q & ~sync_q;
endmodule
`default_nettype wire

// ### core/bsr_shift_reg.sv
/*
  Four-stage shift register with parallel load (left clock) and serial shift (right clock).
  Assumes clocks, mode and data arrive as asynchronous pins, slow against clk_in.
*/
// Overview of operation
// - Four stages, each on its own output.
// - Mode high: load clock fall loads parallel inputs.
// - Serial input ignored while mode high.
// - Mode low: shift clock fall shifts toward stage3.
// - Unselected clock is ignored entirely.
// - Mode change with clock high holds contents.
// - No active edge means stages hold.
`timescale 1ns/10ps
`default_nettype none
module bsr_shift_reg
  import bsr_pkg::*;
#(
  parameter int STAGES = BSR_STAGES
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic mode_in,
  input wire logic load_clk_in,
  input wire logic shift_clk_in,
  input wire logic serial_in,
  input wire logic [STAGES-1:0] parallel_in,
  output logic [STAGES-1:0] stage_out
);
  logic load_fall;
  logic shift_fall;
  logic load_lvl;
  logic shift_lvl;
  logic [BSR_SYNC_DEPTH-1:0] mode_sync_q;
  logic [BSR_SYNC_DEPTH-1:0] mode_sync_d;
  logic [BSR_SYNC_DEPTH-1:0] ser_sync_q;
  logic [BSR_SYNC_DEPTH-1:0] ser_sync_d;
  logic [STAGES-1:0] par_meta_q;
  logic [STAGES-1:0] par_meta_d;
  logic [STAGES-1:0] par_sync_q;
  logic [STAGES-1:0] par_sync_d;
  logic [STAGES-1:0] stage_q;
  logic [STAGES-1:0] stage_d;
  logic mode_now;
  logic ser_now;
  logic loaded_q;
  logic loaded_d;

  // Picks the fall pulse of the clock that the current mode selects; the other clock
  // is refused, so a fall on it must never reach the stages.
  function automatic logic sel_fall(input logic mode_v, input logic load_v,
      input logic shift_v);
    logic res;
    res = (mode_v == BSR_MODE_LOAD) ? load_v : shift_v;
    return res;
  endfunction

  // The data pins pass the same two flops as the clocks, so data stable before a clock
  // fall is seen aligned with that fall.
  bsr_edge_sync u_load_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(load_clk_in),
    .level_out(load_lvl),
    .fall_out(load_fall)
  );

  bsr_edge_sync u_shift_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(shift_clk_in),
    .level_out(shift_lvl),
    .fall_out(shift_fall)
  );

  always_comb begin
    mode_sync_d = {mode_sync_q[BSR_SYNC_DEPTH-2:0], mode_in};
    ser_sync_d = {ser_sync_q[BSR_SYNC_DEPTH-2:0], serial_in};
    par_meta_d = parallel_in;
    par_sync_d = par_meta_q;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_sync_q <= '0;
      ser_sync_q <= '0;
      par_meta_q <= '0;
      par_sync_q <= '0;
    end else begin
      mode_sync_q <= mode_sync_d;
      ser_sync_q <= ser_sync_d;
      par_meta_q <= par_meta_d;
      par_sync_q <= par_sync_d;
    end
  end

  assign mode_now = mode_sync_q[BSR_SYNC_DEPTH-1];
  assign ser_now = ser_sync_q[BSR_SYNC_DEPTH-1];

  // Tracks whether any accepted edge has written the stages since reset. The stages
  // themselves stay unreset, so checks on held contents wait for this flag.
  always_comb begin
    loaded_d = loaded_q | sel_fall(mode_now, load_fall, shift_fall);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      loaded_q <= 1'h0;
    end else begin
      loaded_q <= loaded_d;
    end
  end

  // Only the clock selected by mode acts; a mode change alone never alters a stage.
  always_comb begin
    stage_d = stage_q;
    if (mode_now == BSR_MODE_LOAD) begin
      if (load_fall) begin
        stage_d = par_sync_q;
      end
    end else begin
      if (shift_fall) begin
        stage_d = {stage_q[STAGES-2:0], ser_now};
      end
    end
  end

  // The stages carry no reset so the contents stay undefined until loaded.
  always_ff @(posedge clk_in) begin
    stage_q <= stage_d;
  end

  assign stage_out = stage_q;

  a_load_capture: assert property (@(posedge clk_in) disable iff (rst_in)
    (mode_now && load_fall) |=> (stage_out == $past(par_sync_q)))
    else $error("load did not capture parallel inputs");

  sequence s_load_edge;
    mode_now && load_fall;
  endsequence

  sequence s_shift_edge;
    !mode_now && shift_fall;
  endsequence

  a_shift_move: assert property (@(posedge clk_in) disable iff (rst_in)
    (loaded_q && !mode_now && shift_fall) |=>
      (stage_out[STAGES-1:1] == $past(stage_out[STAGES-2:0])))
    else $error("shift did not move stages");

  a_shift_serial: assert property (@(posedge clk_in) disable iff (rst_in)
    (!mode_now && shift_fall) |=> (stage_out[BSR_FIRST] == $past(ser_now)))
    else $error("stage0 did not take serial level");

  a_load_no_serial: assert property (@(posedge clk_in) disable iff (rst_in)
    (loaded_q && mode_now && !load_fall) |=> $stable(stage_out))
    else $error("stages changed in load mode without load edge");

  a_shift_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
    (loaded_q && mode_now && shift_fall && !load_fall) |=> $stable(stage_out))
    else $error("shift clock acted in load mode");

  a_load_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
    (loaded_q && !mode_now && load_fall && !shift_fall) |=> $stable(stage_out))
    else $error("load clock acted in shift mode");

  a_mode_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (loaded_q && $changed(mode_now) && !load_fall && !shift_fall) |=> $stable(stage_out))
    else $error("mode change altered stages");

  a_idle_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    (loaded_q && !load_fall && !shift_fall) [*2] |=> $stable(stage_out))
    else $error("stages changed without clock edge");

  a_lvl_seen: assert property (@(posedge clk_in) disable iff (rst_in)
    load_fall |-> !load_lvl)
    else $error("load fall with high level");

  // Each pin fall must act once only; a pulse lasting two cycles would shift twice.
  a_load_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    load_fall |=> !load_fall)
    else $error("load fall pulse lasted more than one cycle");

  a_shift_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    shift_fall |=> !shift_fall)
    else $error("shift fall pulse lasted more than one cycle");

  a_shift_lvl: assert property (@(posedge clk_in) disable iff (rst_in)
    shift_fall |-> !shift_lvl)
    else $error("shift fall with high level");

  a_load_seq: assert property (@(posedge clk_in) disable iff (rst_in)
    s_load_edge |=> (stage_out[STAGES-1] == $past(par_sync_q[STAGES-1])))
    else $error("last stage missed its parallel input");

  a_shift_seq: assert property (@(posedge clk_in) disable iff (rst_in)
    (loaded_q && s_shift_edge) |=> (stage_out[STAGES-1] == $past(stage_out[STAGES-2])))
    else $error("last stage missed the stage before it");

  a_first_write: assert property (@(posedge clk_in) disable iff (rst_in)
    (!loaded_q && sel_fall(mode_now, load_fall, shift_fall)) |=> loaded_q)
    else $error("first accepted edge not recorded");

  a_loaded_keep: assert property (@(posedge clk_in) disable iff (rst_in)
    loaded_q |=> loaded_q)
    else $error("written flag dropped without reset");

  a_unloaded_wait: assert property (@(posedge clk_in) disable iff (rst_in)
    (!loaded_q && !load_fall && !shift_fall) |=> !loaded_q)
    else $error("written flag set without an edge");
endmodule
`default_nettype wire

// ### dv/bsr_pins_model.sv
/*
  Model of the driving logic: mode, both clocks, serial and parallel data pins.
  Assumes clk_in is the system clock; every clock and mode level is held at least four cycles, inverted data levels only two.
*/
`timescale 1ns/10ps
`default_nettype none
module bsr_pins_model(
  input wire logic clk_in,
  output logic mode_out,
  output logic load_clk_out,
  output logic shift_clk_out,
  output logic ser_out,
  output logic [3:0] par_out
);
  initial begin
    {mode_out, load_clk_out, shift_clk_out, ser_out, par_out} = 8'h00;
  end
  // Data and mode settle before any clock rises; data is inverted once the hold has passed, mode only on flip while the clocks are high.
  task automatic op(input logic m, input logic [3:0] d, input logic s,
      input logic [1:0] k, input logic flip);
    mode_out <= m;
    par_out <= d;
    ser_out <= s;
    repeat (4) @(posedge clk_in);
    {shift_clk_out, load_clk_out} <= k;
    repeat (4) @(posedge clk_in);
    if (flip) mode_out <= ~m;
    repeat (4) @(posedge clk_in);
    {shift_clk_out, load_clk_out} <= 2'h0;
    repeat (4) @(posedge clk_in);
    ser_out <= ~s;
    par_out <= ~d;
  endtask
endmodule
`default_nettype wire

// ### dv/test_bidirectional_shift_register4.sv
/*
  Self-checking bench: random and directed load and shift operations with a result queue.
  Assumes the design captures an accepted clock fall within six cycles.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module test_bidirectional_shift_register4;
  import bsr_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic mode, lclk, sclk, ser;
  logic [3:0] par, stage, exp_v;
  logic [3:0] exp_q [$];
  logic [31:0] r;
  int error_cnt = 0, checks = 0, cyc = 0, seed = 38;
  event done;
  always #2 clk_in = ~clk_in;
  bsr_pins_model pm(.clk_in(clk_in), .mode_out(mode), .load_clk_out(lclk),
    .shift_clk_out(sclk), .ser_out(ser), .par_out(par));
  bsr_shift_reg dut(.clk_in(clk_in), .rst_in(rst_in), .mode_in(mode), .load_clk_in(lclk),
    .shift_clk_in(sclk), .serial_in(ser), .parallel_in(par), .stage_out(stage));
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic run(input logic m, input logic [3:0] d, input logic s,
      input logic [1:0] k, input logic flip);
    if ((m ? k[0] : k[1]) && !flip) exp_v = m ? d : {exp_v[2:0], s};
    pm.op(m, d, s, k, flip);
    exp_q.push_back(exp_v);
    repeat (2) @(posedge clk_in);
    -> done;
  endtask
  always @(done) begin
    logic [3:0] e;
    e = exp_q.pop_front();
    `CHK("stage_out", e, stage)
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    // The first operation is a load, since stage contents start unknown.
    run(1'h1, 4'ha, 1'h1, 2'h3, 1'h0);
    run(1'h0, 4'h0, 1'h1, 2'h3, 1'h0);
    run(1'h1, 4'h3, 1'h0, 2'h1, 1'h1);
    run(1'h0, 4'hf, 1'h0, 2'h2, 1'h1);
    $display("test directed done");
    for (int i = 0; i < 4; i++) run(1'h1, {i[0], exp_v[3:1]}, 1'h0, 2'h1, 1'h0);
    $display("test left shift done");
    for (int i = 0; i < 200; i++) begin
      r = $random(seed);
      run(r[0], r[4:1], r[5], r[7:6], r[8] && r[7:6] == (r[0] ? 2'h1 : 2'h2));
    end
    $display("test random done");
    close_out();
  end
endmodule
`default_nettype wire
